/* src/uipf_top.sv */
// interrupt identification, prioritisation and fifo control of a serial port
// assumes an outside receive fifo and transmitter reporting level and events
`timescale 1ns/10ps
module uipf_top #(
  parameter int LVL_W = 5,
  parameter int TOUT_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] rx_data_i,
  input wire logic [LVL_W-1:0] rx_level_i,
  input wire logic rx_push_i,
  input wire logic overrun_i,
  input wire logic parity_err_i,
  input wire logic framing_err_i,
  input wire logic break_i,
  input wire logic tx_empty_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic dcd_i,
  input wire logic ri_i,
  output logic rx_pop_o,
  output logic tx_load_o,
  output logic [7:0] tx_data_o,
  output logic rx_clear_o,
  output logic tx_clear_o,
  output logic irq_o
);
  logic [1:0] trig_sel;
  logic [4:0] mask;
  logic [4:0] stat;
  logic [TOUT_W-1:0] tout_set;
  logic [TOUT_W-1:0] tout_cnt;
  logic [3:0] lsr_err; // break, framing, parity, overrun
  logic [3:0] msr_delta; // dcd, ri trailing, dsr, cts
  logic [3:0] modem_prev;
  logic tx_prev;
  logic primed;
  logic rda_pend;
  logic tout_pend;
  logic thre_pend;
  logic [4:0] pend;
  logic [4:0] eff;
  logic [3:0] code;
  logic [7:0] trig_lvl;
  logic acc, wr, rd, wr0;
  logic rd_ident, rd_lsr, rd_msr, rd_rbr, wr_thr, wr_fcr;
  logic [3:0] modem_now;
  logic [3:0] modem_chg;
  logic [3:0] err_now;
  logic tx_rise;
  logic tout_idle;
  logic tout_hit;
  logic rda_now;

  // bus decode: access taken in the cycle before ack
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;
  assign rd = acc && !wb_we_i;
  assign wr0 = wr && wb_sel_i[0];
  assign rd_ident = rd && (wb_adr_i == uipf_pkg::ADDR_IDENT);
  assign rd_lsr = rd && (wb_adr_i == uipf_pkg::ADDR_LSR);
  assign rd_msr = rd && (wb_adr_i == uipf_pkg::ADDR_MSR);
  assign rd_rbr = rd && (wb_adr_i == uipf_pkg::ADDR_DATA);
  assign wr_thr = wr0 && (wb_adr_i == uipf_pkg::ADDR_DATA);
  assign wr_fcr = wr0 && (wb_adr_i == uipf_pkg::ADDR_IDENT);

  // event detection on line errors, modem lines and transmitter
  assign err_now = {break_i, framing_err_i, parity_err_i, overrun_i};
  assign modem_now = {dcd_i, ri_i, dsr_i, cts_i};
  assign modem_chg = primed ? {modem_now[3] ^ modem_prev[3],
                               modem_prev[2] & ~modem_now[2], // R5
                               modem_now[1:0] ^ modem_prev[1:0]} : 4'h0;
  assign tx_rise = primed && tx_empty_i && !tx_prev;

  // trigger selector to byte level
  always_comb begin
    unique case (trig_sel)
      2'b00: trig_lvl = uipf_pkg::TRIG_LVL_0; // R8
      2'b01: trig_lvl = uipf_pkg::TRIG_LVL_1; // R8
      2'b10: trig_lvl = uipf_pkg::TRIG_LVL_2; // R8
      2'b11: trig_lvl = uipf_pkg::TRIG_LVL_3;
    endcase
  end
  assign rda_now = 8'(rx_level_i) >= trig_lvl; // R2

  // receive idle counter restarts on any fifo activity
  assign tout_idle = (rx_level_i == '0) || rx_push_i || rd_rbr;
  assign tout_hit = !tout_idle && (tout_cnt == tout_set); // R3

  // pending sources, masked by enables, priority encoded
  assign pend = {|msr_delta, thre_pend, tout_pend, rda_pend, |lsr_err};
  assign eff = pend & mask;
  always_comb begin
    if (eff[uipf_pkg::SRC_LS]) begin
      code = uipf_pkg::CODE_LS; // R1 R9 R10
    end else if (eff[uipf_pkg::SRC_RDA]) begin
      code = uipf_pkg::CODE_RDA; // R2 R10
    end else if (eff[uipf_pkg::SRC_TOUT]) begin
      code = uipf_pkg::CODE_TOUT; // R3 R10
    end else if (eff[uipf_pkg::SRC_THRE]) begin
      code = uipf_pkg::CODE_THRE; // R4 R10
    end else if (eff[uipf_pkg::SRC_MOS]) begin
      code = uipf_pkg::CODE_MOS; // R5 R10
    end else begin
      code = uipf_pkg::CODE_NONE; // R7
    end
  end

  // bus answer: ack and read data one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= acc;
      if (rd) begin
        unique case (wb_adr_i)
          uipf_pkg::ADDR_DATA: wb_dat_o <= {24'h0, rx_data_i};
          uipf_pkg::ADDR_MASK: wb_dat_o <= {27'h0, mask};
          uipf_pkg::ADDR_IDENT: wb_dat_o <= {24'h0, 1'b1, trig_sel,
                                             1'b0, code}; // R9
          uipf_pkg::ADDR_LSR: wb_dat_o <= {26'h0, tx_empty_i, lsr_err,
                                           rx_level_i != '0};
          uipf_pkg::ADDR_MSR: wb_dat_o <= {24'h0, modem_now, msr_delta};
          uipf_pkg::ADDR_TOUT: wb_dat_o <= 32'(tout_set);
          uipf_pkg::ADDR_STAT: wb_dat_o <= {27'h0, stat};
          default: wb_dat_o <= 32'h0; // unmapped reads zero
        endcase
      end
    end
  end

  // software settings: fifo control, mask, time-out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_sel <= uipf_pkg::TRIG_RST;
      mask <= uipf_pkg::MASK_RST;
      tout_set <= TOUT_W'(uipf_pkg::TOUT_RST);
    end else begin
      if (wr_fcr) begin
        trig_sel <= wb_dat_i[uipf_pkg::FC_TRIG_HI:uipf_pkg::FC_TRIG_LO]; // R6
      end
      if (wr0 && wb_adr_i == uipf_pkg::ADDR_MASK) begin
        mask <= wb_dat_i[4:0];
      end
      if (wr0 && wb_adr_i == uipf_pkg::ADDR_TOUT) begin
        tout_set <= wb_dat_i[TOUT_W-1:0];
      end
    end
  end

  // one-cycle strobes to the fifos and transmitter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_pop_o <= 1'b0;
      tx_load_o <= 1'b0;
      tx_data_o <= 8'h0;
      rx_clear_o <= 1'b0;
      tx_clear_o <= 1'b0;
    end else begin
      rx_pop_o <= rd_rbr;
      tx_load_o <= wr_thr;
      rx_clear_o <= wr_fcr && wb_dat_i[uipf_pkg::FC_RXCLR];
      tx_clear_o <= wr_fcr && wb_dat_i[uipf_pkg::FC_TXCLR];
      if (wr_thr) begin
        tx_data_o <= wb_dat_i[7:0];
      end
    end
  end

  // previous levels for edge detection, primed after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primed <= 1'b0;
      modem_prev <= 4'h0;
      tx_prev <= 1'b0;
    end else begin
      primed <= 1'b1;
      modem_prev <= modem_now;
      tx_prev <= tx_empty_i;
    end
  end

  // line errors and modem deltas: new events win over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lsr_err <= 4'h0;
      msr_delta <= 4'h0;
    end else begin
      lsr_err <= (rd_lsr ? 4'h0 : lsr_err) | err_now; // R1
      msr_delta <= (rd_msr ? 4'h0 : msr_delta) | modem_chg; // R5
    end
  end

  // data available follows the fill level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rda_pend <= 1'b0;
    end else begin
      rda_pend <= rda_now; // R2
    end
  end

  // receive time-out counter and pending flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tout_cnt <= '0;
      tout_pend <= 1'b0;
    end else begin
      if (tout_idle) begin
        tout_cnt <= '0;
      end else if (tout_cnt != tout_set) begin
        tout_cnt <= TOUT_W'(tout_cnt + 1'b1);
      end
      if (tout_hit) begin
        tout_pend <= 1'b1; // R3
      end else if (rd_rbr) begin
        tout_pend <= 1'b0; // R3
      end
    end
  end

  // transmit holding empty: rise sets, write or ident read of it clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thre_pend <= 1'b0;
    end else if (tx_rise) begin
      thre_pend <= 1'b1; // R4
    end else if (wr_thr || (rd_ident && code == uipf_pkg::CODE_THRE)) begin
      thre_pend <= 1'b0; // R4
    end
  end

  // sticky status, write one to clear, set wins; masked level irq
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= 5'h00;
      irq_o <= 1'b0;
    end else begin
      if (wr0 && wb_adr_i == uipf_pkg::ADDR_STAT) begin
        stat <= (stat & ~wb_dat_i[4:0]) | pend;
      end else begin
        stat <= stat | pend;
      end
      irq_o <= |(stat & mask);
    end
  end

  // checks on the identification and clearing behaviour
  ls_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    rd_ident && eff[uipf_pkg::SRC_LS] |=> wb_dat_o[3:0] == 4'h6)
    else $error("line status code wrong");
  ls_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    rd_lsr && err_now == 4'h0 |=> !pend[uipf_pkg::SRC_LS])
    else $error("line status not cleared by read");
  rda_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    ##1 rda_pend == $past(8'(rx_level_i) >= trig_lvl))
    else $error("data available does not follow level");
  tout_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    rd_rbr |=> !tout_pend)
    else $error("time-out not cleared by buffer read");
  thre_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    wr_thr && !tx_rise |=> !thre_pend)
    else $error("holding empty not cleared by write");
  mos_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    primed && $changed(cts_i) |=> pend[uipf_pkg::SRC_MOS])
    else $error("modem change not flagged");
  trig_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    wr_fcr |=> trig_sel == $past(wb_dat_i[7:6]))
    else $error("trigger selector not taken");
  none_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    rd_ident && eff == 5'h00 |=> wb_dat_o[7:0] == {1'b1, trig_sel, 5'h01})
    else $error("no-pending code wrong");
  trig_map_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    trig_sel == 2'b01 |-> trig_lvl == 8'h04)
    else $error("trigger level map wrong");
  prio_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    rd_ident && eff[3:0] == 4'h8 |=> wb_dat_o[3:0] == 4'h2)
    else $error("lower source shown wrongly");
  ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  thre_ident_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    rd_ident && code == uipf_pkg::CODE_THRE && !tx_rise |=> !thre_pend)
    else $error("holding empty not cleared by ident read");
  ri_trail_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    primed && $fell(ri_i) |=> pend[uipf_pkg::SRC_MOS])
    else $error("ring trailing edge not flagged");
  ls_over_rda_c: cover property (@(posedge clk_i) disable iff (rst_i)
    rd_ident && eff[0] && eff[1]);
  tout_fire_c: cover property (@(posedge clk_i) disable iff (rst_i)
    tout_hit ##1 tout_pend);
  thre_ident_c: cover property (@(posedge clk_i) disable iff (rst_i)
    rd_ident && code == uipf_pkg::CODE_THRE);
  irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule : uipf_top

/* src/uipf_pkg.sv */
// constants, register map and codes of the serial-port interrupt logic
// assumes a classic Wishbone slave on a 32-bit bus, byte addresses
//
// What this block does
// [R1] line status error pending reports code 0110 first; reading line status clears
// [R2] receive fill at trigger level reports 0100; clears when fill drops below
// [R3] receive fifo idle past time-out reports 1100; reading receive buffer clears
// [R4] transmit holding empty reports 0010; ident read of it or data write clears
// [R5] modem line change or ring trailing edge reports 0000; modem read clears
// [R6] fifo control bits 7:6 select the receive trigger level
// [R7] no-pending flag bit 0 is 1 and code reads 1 when nothing pends
// [R8] trigger selector 00 gives 1 byte, 01 gives 4, 10 gives 8
// [R9] ident bits 3:1 plus bit 0 show the top active request code
// [R10] only the highest pending source shows; lower ones appear once it clears
package uipf_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_DATA = 8'h00; // rx buffer read, tx write
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_IDENT = 8'h08; // ident read, fifo control write
  localparam logic [7:0] ADDR_LSR = 8'h14;
  localparam logic [7:0] ADDR_MSR = 8'h18;
  localparam logic [7:0] ADDR_TOUT = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h24;
  // source bit positions in pending, status and mask vectors
  localparam int SRC_LS = 0;
  localparam int SRC_RDA = 1;
  localparam int SRC_TOUT = 2;
  localparam int SRC_THRE = 3;
  localparam int SRC_MOS = 4;
  localparam int NSRC = 5;
  // identification codes, bits 3:0
  localparam logic [3:0] CODE_NONE = 4'h1;
  localparam logic [3:0] CODE_LS = 4'h6;
  localparam logic [3:0] CODE_RDA = 4'h4;
  localparam logic [3:0] CODE_TOUT = 4'hc;
  localparam logic [3:0] CODE_THRE = 4'h2;
  localparam logic [3:0] CODE_MOS = 4'h0;
  // fifo control fields
  localparam int FC_TRIG_HI = 7;
  localparam int FC_TRIG_LO = 6;
  localparam int FC_TXCLR = 2;
  localparam int FC_RXCLR = 1;
  // trigger levels in bytes
  localparam logic [7:0] TRIG_LVL_0 = 8'h01;
  localparam logic [7:0] TRIG_LVL_1 = 8'h04;
  localparam logic [7:0] TRIG_LVL_2 = 8'h08;
  localparam logic [7:0] TRIG_LVL_3 = 8'h0e;
  // values after reset
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [7:0] TOUT_RST = 8'h40;
endpackage : uipf_pkg

/* dv/uipf_peer.sv */
// partner model: outside rx fifo, transmitter and modem lines
// assumes bench commands arrive as one-cycle pulses or levels
`timescale 1ns/10ps
module uipf_peer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [3:0] err_i,
  input wire logic tx_done_i,
  input wire logic [3:0] modem_i,
  input wire logic rx_pop_i,
  input wire logic tx_load_i,
  output logic [4:0] rx_level_o,
  output logic rx_push_o,
  output logic [7:0] rx_data_o,
  output logic [3:0] line_err_o,
  output logic tx_empty_o,
  output logic [3:0] modem_o
);
  // fill count follows pushes and pops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_level_o <= 5'h00;
      rx_push_o <= 1'b0;
    end else begin
      rx_level_o <= rx_level_o + 5'(push_i) - 5'(rx_pop_i);
      rx_push_o <= push_i;
    end
  end
  // head byte changes with the fill
  assign rx_data_o = {3'h5, rx_level_o};
  // transmitter empties when told, fills on load
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_done_i) begin
      tx_empty_o <= 1'b1;
    end else if (tx_load_i) begin
      tx_empty_o <= 1'b0;
    end
  end
  // error and modem lines follow the bench one cycle later
  always_ff @(posedge clk_i) begin
    line_err_o <= err_i;
    modem_o <= modem_i;
  end
endmodule : uipf_peer

/* dv/uipf_top_bench.sv */
// self-checking bench of the serial-port interrupt logic
// assumes the peer model stands in for fifo, transmitter and modem
`timescale 1ns/10ps
module uipf_top_bench;
  logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic push = 1'b0, txd = 1'b0, pop, load, irq, rpush, txe;
  logic [7:0] adr = 8'h00, rxd, txdat;
  logic [3:0] sel = 4'h0, err = 4'h0, modem = 4'h0, lerr, mline;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [4:0] lvl;
  logic rxclr, txclr;
  int fails = 0, n_checks = 0, cyc_n = 0, lv;
  int n_rxclr = 0, n_txclr = 0;
  uipf_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_data_i(rxd),
    .rx_level_i(lvl), .rx_push_i(rpush), .overrun_i(lerr[0]),
    .parity_err_i(lerr[1]), .framing_err_i(lerr[2]), .break_i(lerr[3]),
    .tx_empty_i(txe), .cts_i(mline[0]), .dsr_i(mline[1]),
    .dcd_i(mline[2]), .ri_i(mline[3]), .rx_pop_o(pop), .tx_load_o(load),
    .tx_data_o(txdat), .rx_clear_o(rxclr), .tx_clear_o(txclr),
    .irq_o(irq));
  uipf_peer u_peer (.clk_i(clk_i), .rst_i(rst_i), .push_i(push),
    .err_i(err), .tx_done_i(txd), .modem_i(modem), .rx_pop_i(pop),
    .tx_load_i(load), .rx_level_o(lvl), .rx_push_o(rpush),
    .rx_data_o(rxd), .line_err_o(lerr), .tx_empty_o(txe),
    .modem_o(mline));
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // fifo clear strobes counted where they stand
  always @(posedge clk_i) begin
    if (rxclr === 1'b1) n_rxclr++;
    if (txclr === 1'b1) n_txclr++;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      results();
    end
  end
  task results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // classic single cycle, held until ack is seen
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  task rd(input logic [1:0] s, input logic [3:0] c);
    wb(1'b0, uipf_pkg::ADDR_IDENT, 32'h0);
    chk("ident", {24'h0, 1'b1, s, 1'b0, c}, q);
  endtask : rd
  task pushn(input int n);
    repeat (n) begin
      @(posedge clk_i) push <= 1'b1;
      @(posedge clk_i) push <= 1'b0;
    end
  endtask : pushn
  // selectors 00 to 10 against their byte levels
  task t_trig;
    for (int s = 0; s < 3; s++) begin
      lv = (s == 0) ? 1 : (s == 1) ? 4 : 8;
      wb(1'b1, uipf_pkg::ADDR_IDENT, {24'h0, 2'(s), 6'h0});
      pushn(lv - 1);
      idle(3);
      rd(2'(s), uipf_pkg::CODE_NONE);
      pushn(1);
      idle(3);
      rd(2'(s), uipf_pkg::CODE_RDA);
      wb(1'b0, uipf_pkg::ADDR_DATA, 32'h0);
      chk("rx_data", 32'({3'h5, 5'(lv)}), q);
      idle(3);
      rd(2'(s), uipf_pkg::CODE_NONE);
      repeat (lv - 1) wb(1'b0, uipf_pkg::ADDR_DATA, 32'h0);
    end
    wb(1'b1, uipf_pkg::ADDR_IDENT, 32'h0);
  endtask : t_trig
  // line status, data available and modem change at once, cleared one by one
  task t_prio;
    pushn(1);
    @(posedge clk_i) err <= 4'h1;
    modem <= 4'h1;
    @(posedge clk_i) err <= 4'h0;
    idle(3);
    rd(2'h0, uipf_pkg::CODE_LS);
    wb(1'b0, uipf_pkg::ADDR_LSR, 32'h0);
    chk("line_status", 32'h23, q);
    idle(2);
    rd(2'h0, uipf_pkg::CODE_RDA);
    wb(1'b0, uipf_pkg::ADDR_DATA, 32'h0);
    idle(2);
    rd(2'h0, uipf_pkg::CODE_MOS);
    wb(1'b0, uipf_pkg::ADDR_MSR, 32'h0);
    chk("modem_status", 32'h11, q);
    idle(2);
    rd(2'h0, uipf_pkg::CODE_NONE);
    @(posedge clk_i) modem <= 4'h9;
    idle(4);
    rd(2'h0, uipf_pkg::CODE_NONE);
    @(posedge clk_i) modem <= 4'h1;
    idle(4);
    rd(2'h0, uipf_pkg::CODE_MOS);
    wb(1'b0, uipf_pkg::ADDR_MSR, 32'h0);
  endtask : t_prio
  // idle fifo past a short time-out
  task t_tout;
    wb(1'b1, uipf_pkg::ADDR_IDENT, 32'h80);
    wb(1'b1, uipf_pkg::ADDR_TOUT, 32'h10);
    pushn(1);
    idle(30);
    rd(2'h2, uipf_pkg::CODE_TOUT);
    wb(1'b0, uipf_pkg::ADDR_DATA, 32'h0);
    idle(2);
    rd(2'h2, uipf_pkg::CODE_NONE);
    wb(1'b1, uipf_pkg::ADDR_IDENT, 32'h0);
  endtask : t_tout
  // holding empty cleared by ident read, then by a data write
  task t_thre;
    wb(1'b1, uipf_pkg::ADDR_DATA, 32'h5a);
    chk("tx_data", 32'h5a, {24'h0, txdat});
    repeat (2) begin
      @(posedge clk_i) txd <= 1'b1;
      @(posedge clk_i) txd <= 1'b0;
      idle(3);
    end
    rd(2'h0, uipf_pkg::CODE_THRE);
    rd(2'h0, uipf_pkg::CODE_NONE);
    wb(1'b1, uipf_pkg::ADDR_DATA, 32'h33);
    @(posedge clk_i) txd <= 1'b1;
    @(posedge clk_i) txd <= 1'b0;
    idle(3);
    wb(1'b1, uipf_pkg::ADDR_DATA, 32'h44);
    idle(2);
    rd(2'h0, uipf_pkg::CODE_NONE);
  endtask : t_thre
  // masked event, sticky status, level output
  task t_irq;
    wb(1'b1, uipf_pkg::ADDR_STAT, 32'h1f);
    wb(1'b1, uipf_pkg::ADDR_MASK, 32'h0);
    @(posedge clk_i) modem <= 4'h0;
    idle(4);
    chk("irq", 32'h0, {31'h0, irq});
    rd(2'h0, uipf_pkg::CODE_NONE);
    wb(1'b0, uipf_pkg::ADDR_STAT, 32'h0);
    chk("status", 32'h10, q);
    wb(1'b1, uipf_pkg::ADDR_MASK, 32'h1f);
    idle(3);
    chk("irq", 32'h1, {31'h0, irq});
    wb(1'b0, uipf_pkg::ADDR_MSR, 32'h0);
    wb(1'b1, uipf_pkg::ADDR_STAT, 32'h10);
    idle(3);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_irq
  // reset in mid-run brings settings back to their reset values
  task t_reset;
    wb(1'b1, uipf_pkg::ADDR_IDENT, 32'h40);
    @(posedge clk_i) rst_i <= 1'b1;
    idle(2);
    @(posedge clk_i) rst_i <= 1'b0;
    chk("irq", 32'h0, {31'h0, irq});
    rd(2'h0, uipf_pkg::CODE_NONE);
    wb(1'b0, uipf_pkg::ADDR_TOUT, 32'h0);
    chk("timeout", 32'h40, q);
    wb(1'b0, uipf_pkg::ADDR_MASK, 32'h0);
    chk("mask", 32'h0, q);
  endtask : t_reset
  // main sequence
  initial begin
    idle(2);
    rst_i <= 1'b0;
    rd(2'h0, uipf_pkg::CODE_NONE);
    wb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, uipf_pkg::ADDR_MASK, 32'h1f);
    wb(1'b1, uipf_pkg::ADDR_TOUT, 32'hff);
    wb(1'b0, uipf_pkg::ADDR_MASK, 32'h0);
    chk("mask", 32'h1f, q);
    wb(1'b1, uipf_pkg::ADDR_IDENT, 32'h6);
    idle(1);
    chk("rx_clear", 32'h1, n_rxclr);
    chk("tx_clear", 32'h1, n_txclr);
    t_trig();
    t_prio();
    t_tout();
    t_thre();
    t_irq();
    t_reset();
    results();
  end
endmodule : uipf_top_bench
